// [dv/mlpr_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: drives the datapath controls and drains the spill stream
module mlpr_host
   import mlpr_pkg::*;
(
   // clock
   input  wire logic     i_core_clk,
   // datapath drive
   output var mlpr_word_t o_word,
   output logic [3:0]    o_op,
   output logic [2:0]    o_pick,
   output logic          o_cen_n,
   output logic          o_oe_n,
   // spill drain
   output logic          o_ready
);
   initial begin
      o_word  = 16'h0000;
      o_op    = OP_HOLD;
      o_pick  = 3'h0;
      o_cen_n = 1'b1;
      o_oe_n  = 1'b0;
      o_ready = 1'b0;
   end
   // controls move just after an edge and stay put until the next one
   task automatic drive(input logic [3:0] op, input mlpr_word_t w, input logic cen_n);
      @(posedge i_core_clk);
      o_op    <= op;
      o_word  <= w;
      o_cen_n <= cen_n;
   endtask : drive
   // idle cycle: word is stale, so it toggles rather than lingering
   task automatic show(input logic [2:0] p, input logic oe_n);
      @(posedge i_core_clk);
      o_pick  <= p;
      o_oe_n  <= oe_n;
      o_cen_n <= 1'b1;
      o_word  <= ~o_word;
   endtask : show
   task automatic drain(input logic r);
      @(posedge i_core_clk);
      o_ready <= r;
   endtask : drain
endmodule : mlpr_host
`default_nettype wire

// [dv/test_multilevel_pipeline_register.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_multilevel_pipeline_register
   import mlpr_pkg::*;
;
   logic        i_core_clk = 1'b0;
   logic        i_rst_n    = 1'b0;
   logic [3:0]  addr       = 4'h0;
   logic [31:0] wdata      = 32'h0;
   logic        wr         = 1'b0;
   logic        rd         = 1'b0;
   logic [31:0] rdata, got;
   mlpr_word_t  word, wout, y, sword;
   mlpr_word_t  nw         = 16'h0000;
   logic [3:0]  op;
   logic [2:0]  pick;
   logic        cen_n, oe_n, ready, oe, svalid;
   logic        seven      = 1'b0;
   logic        spill      = 1'b0;
   mlpr_word_t  exp_r [8];
   mlpr_word_t  q [$];
   int          fails       = 0;
   int          comparisons = 0;

   always #2 i_core_clk = ~i_core_clk;
   // pin level seen by the host: floats when not driven
   assign y = oe ? wout : 16'hzzzz;

   mlpr_host host (.i_core_clk(i_core_clk), .o_word(word), .o_op(op), .o_pick(pick),
                   .o_cen_n(cen_n), .o_oe_n(oe_n), .o_ready(ready));
   mlpr_top uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_word_in(word), .i_op_code(op),
                 .i_output_pick(pick), .i_clock_enable_n(cen_n), .i_output_enable_n(oe_n),
                 .o_word_out(wout), .o_word_out_oe(oe), .o_spill_valid(svalid),
                 .i_spill_ready(ready), .o_spill_word(sword), .i_reg_addr(addr),
                 .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge i_core_clk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a);
      @(posedge i_core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge i_core_clk);
      rd   <= 1'b0;
      #1 got = rdata;
   endtask : reg_rd

   // reference bank; with spill set, the word dropped off the top of a chain goes to q
   function automatic void step(input logic [3:0] c, input mlpr_word_t w);
      int lo, hi;
      lo = 0;
      hi = -1;
      case (c)
         4'h8: hi = seven ? 6 : 7;
         4'h9: hi = 3;
         4'ha: begin lo = 4; hi = seven ? 6 : 7; end
         4'hb: hi = 1;
         4'hc: begin lo = 2; hi = 3; end
         4'hd: begin lo = 4; hi = 5; end
         4'he: if (seven) exp_r[6] = w; else begin lo = 6; hi = 7; end
         4'hf: ;
         default: if (!(seven && c == 4'h7)) exp_r[c[2:0]] = w;
      endcase
      if (hi >= 0) begin
         if (spill) q.push_back(exp_r[hi]);
         for (int i = hi; i > lo; i--) exp_r[i] = exp_r[i-1];
         exp_r[lo] = w;
      end
   endfunction : step

   task automatic do_op(input logic [3:0] c);
      nw = nw + 16'h1357;
      host.drive(c, nw, 1'b0);
      step(c, nw);
   endtask : do_op

   // walks every pick; mux must follow the pick without a further edge
   task automatic check_all();
      for (int p = 0; p < 8; p++) begin
         host.show(p[2:0], 1'b0);
         #1;
         if (p == 7 && seven) `CHK(y, word)
         else `CHK(y, exp_r[p])
      end
   endtask : check_all

   task automatic summarize();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize

   initial begin
      #40000;
      fails++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      reg_rd(ADDR_CTRL);
      `CHK(got, 32'h0)
      reg_rd(4'h2);
      `CHK(got, 32'h0)
      $display("test reset done");
      for (int c = 0; c < 8; c++) do_op(c[3:0]);
      check_all();
      for (int c = 0; c < 16; c++) begin
         do_op(c[3:0]);
         check_all();
      end
      host.drive(4'h8, 16'hbeef, 1'b1);
      check_all();
      host.show(3'h3, 1'b0);
      do_op(4'h0);
      @(posedge i_core_clk);
      #1 `CHK(y, exp_r[3])
      host.show(3'h0, 1'b1);
      #1 `CHK(y, 16'hzzzz)
      $display("test eight done");
      reg_wr(ADDR_CTRL, 32'h1);
      seven = 1'b1;
      for (int c = 0; c < 16; c++) begin
         do_op(c[3:0]);
         check_all();
      end
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      seven = 1'b0;
      reg_rd(ADDR_CTRL);
      `CHK(got, 32'h0)
      check_all();
      reg_wr(ADDR_PEEK_SEL, 32'h5);
      reg_rd(ADDR_PEEK_DATA);
      `CHK(got[15:0], exp_r[5])
      $display("test seven done");
      // drain side stalls while the buffer fills to the brim
      reg_wr(ADDR_CTRL, 32'h2);
      spill = 1'b1;
      for (int i = 0; i < 32; i++) do_op(4'hb);
      host.show(3'h0, 1'b0);
      reg_rd(ADDR_STATUS);
      `CHK(got[5:0], 6'h20)
      `CHK(got[15:12], 4'hb)
      host.drive(4'h9, 16'h7777, 1'b0);
      reg_rd(ADDR_STATUS);
      `CHK(got[8], 1'b1)
      check_all();
      host.drain(1'b1);
      #1;
      for (int i = 0; i < 32; i++) begin
         `CHK(sword, q[i])
         @(posedge i_core_clk);
         #1;
      end
      `CHK(svalid, 1'b0)
      $display("test spill done");
      summarize();
   end
endmodule : test_multilevel_pipeline_register
`default_nettype wire

// [hdl/mlpr_top.sv]
`timescale 1ns/1ps
`default_nettype none

// spill buffer: words falling off the end of a delay line
module mlpr_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   // clock and reset
   input  wire logic                     i_core_clk,
   input  wire logic                     i_rst_n,
   // fill side
   input  wire logic                     i_valid,
   output logic                          o_ready,
   input  wire logic [WIDTH-1:0]         i_data,
   // drain side
   output logic                          o_valid,
   input  wire logic                     i_ready,
   output logic [WIDTH-1:0]              o_data,
   // fill level
   output logic [$clog2(DEPTH):0]        o_level
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wp_r;
   logic [PW-1:0]    rp_r;
   logic [PW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign o_ready = (cnt_r != (PW+1)'(DEPTH));
   assign o_valid = (cnt_r != '0);
   assign o_data  = mem_r[rp_r];
   assign o_level = cnt_r;
   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_r[wp_r] <= i_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + PW'(1);
         end
         if (pop) begin
            rp_r <= rp_r + PW'(1);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + (PW+1)'(1);
         end else if (pop && !push) begin
            cnt_r <= cnt_r - (PW+1)'(1);
         end
      end
   end
endmodule : mlpr_fifo

module mlpr_top
   import mlpr_pkg::*;
(
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   // datapath controls
   input  wire logic [WORD_W-1:0] i_word_in,
   input  wire logic [3:0]        i_op_code,
   input  wire logic [2:0]        i_output_pick,
   input  wire logic              i_clock_enable_n,
   input  wire logic              i_output_enable_n,
   // output port
   output logic [WORD_W-1:0]      o_word_out,
   output logic                   o_word_out_oe,
   // spill stream
   output logic                   o_spill_valid,
   input  wire logic              i_spill_ready,
   output logic [WORD_W-1:0]      o_spill_word,
   // register port
   input  wire logic [3:0]        i_reg_addr,
   input  wire logic [31:0]       i_reg_wdata,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   output logic [31:0]            o_reg_rdata
);
   mlpr_ctl_s         ctl_r;
   mlpr_ctl_s         ctl_nxt;
   mlpr_bank_t        bank_r;
   mlpr_bank_t        bank_nxt;
   mlpr_bus_s         bus;
   logic [2:0]        lo;
   logic [2:0]        hi;
   logic              act;
   logic              spill_push;
   logic              fifo_ready;
   logic              stall;
   logic              move;
   logic [LEVEL_W-1:0] level;

   assign bus = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

   // decode code into one chain lo..hi: lo takes the word, each higher stage its neighbour
   always_comb begin
      lo  = 3'h0;
      hi  = 3'h0;
      act = 1'b1;
      if (!i_op_code[3]) begin
         lo = i_op_code[2:0];
         hi = i_op_code[2:0];
         if (ctl_r.seven_mode && i_op_code == OP_LOAD_LAST) begin
            act = 1'b0;
         end
      end else begin
         unique case (i_op_code)
            OP_SHIFT_ALL: begin
               hi = ctl_r.seven_mode ? 3'h6 : 3'h7;
            end
            OP_SHIFT_FIRST4: begin
               hi = 3'h3;
            end
            OP_SHIFT_UPPER: begin
               lo = 3'h4;
               hi = ctl_r.seven_mode ? 3'h6 : 3'h7;
            end
            OP_PAIR_ONE: begin
               hi = 3'h1;
            end
            OP_PAIR_TWO: begin
               lo = 3'h2;
               hi = 3'h3;
            end
            OP_PAIR_THREE: begin
               lo = 3'h4;
               hi = 3'h5;
            end
            OP_PAIR_FOUR: begin
               lo = 3'h6;
               hi = ctl_r.seven_mode ? 3'h6 : 3'h7;
            end
            OP_HOLD: begin
               act = 1'b0;
            end
            default: begin
               act = 1'b0;
            end
         endcase
      end
   end

   // a shift drops the word at stage hi; with spill on it must fit in the buffer first
   assign spill_push = ctl_r.spill_en & act & (hi != lo) & ~i_clock_enable_n;
   assign stall      = spill_push & ~fifo_ready;
   assign move       = ~i_clock_enable_n & act & ~stall;

   always_comb begin
      bank_nxt = bank_r;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (move && 3'(i) == lo) begin
            bank_nxt[i] = i_word_in;
         end else if (move && 3'(i) > lo && 3'(i) <= hi) begin
            bank_nxt[i] = bank_r[3'(i - 1)];
         end
      end
   end

   // no reset on the bank: power-up contents are undefined
   always_ff @(posedge i_core_clk) begin
      bank_r <= bank_nxt;
   end

   always_comb begin
      ctl_nxt         = ctl_r;
      ctl_nxt.rd_data = 32'h0;
      if (move) begin
         ctl_nxt.last_op = i_op_code;
      end
      if (bus.wr) begin
         if (bus.addr == ADDR_CTRL) begin
            ctl_nxt.seven_mode = bus.wdata[CTRL_SEVEN_BIT];
            ctl_nxt.spill_en   = bus.wdata[CTRL_SPILL_BIT];
         end
         if (bus.addr == ADDR_PEEK_SEL) begin
            ctl_nxt.peek_sel = bus.wdata[2:0];
         end
      end
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_CTRL: begin
               ctl_nxt.rd_data[CTRL_SEVEN_BIT] = ctl_r.seven_mode;
               ctl_nxt.rd_data[CTRL_SPILL_BIT] = ctl_r.spill_en;
            end
            ADDR_STATUS: begin
               ctl_nxt.rd_data[LEVEL_W-1:0]               = level;
               ctl_nxt.rd_data[STAT_STALL_BIT]            = stall;
               ctl_nxt.rd_data[STAT_OP_LSB+3:STAT_OP_LSB] = ctl_r.last_op;
            end
            ADDR_PEEK_SEL: begin
               ctl_nxt.rd_data[2:0] = ctl_r.peek_sel;
            end
            ADDR_PEEK_DATA: begin
               ctl_nxt.rd_data[WORD_W-1:0] = bank_r[ctl_r.peek_sel];
            end
            default: begin
               ctl_nxt.rd_data = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_r            <= '0;
         ctl_r.seven_mode <= RST_SEVEN;
         ctl_r.spill_en   <= RST_SPILL;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   assign o_reg_rdata = ctl_r.rd_data;

   mlpr_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (SPILL_DEPTH)
   ) u_spill (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_valid    (spill_push & move),
      .o_ready    (fifo_ready),
      .i_data     (bank_r[hi]),
      .o_valid    (o_spill_valid),
      .i_ready    (i_spill_ready),
      .o_data     (o_spill_word),
      .o_level    (level)
   );

   // read path is pure mux, never gated by the op code, so a select change needs no edge
   always_comb begin
      if (ctl_r.seven_mode && i_output_pick == 3'h7) begin
         o_word_out = i_word_in;
      end else begin
         o_word_out = bank_r[i_output_pick];
      end
   end
   assign o_word_out_oe = ~i_output_enable_n;

   // checks; the bank powers up unknown, so whole-bank compares use case equality
   sequence s_go(logic [3:0] code);
      move && i_op_code == code;
   endsequence

   sequence s_go_in(logic [3:0] code, logic seven);
      move && i_op_code == code && ctl_r.seven_mode == seven;
   endsequence

   chk_hold_disabled: assert property (@(posedge i_core_clk)
      i_clock_enable_n |=> bank_r === $past(bank_r))
      else $error("bank changed with clock enable high");
   chk_single_load: assert property (@(posedge i_core_clk)
      move && !i_op_code[3] |=> bank_r[$past(i_op_code[2:0])] == $past(i_word_in))
      else $error("single load missed its register");
   chk_shift_eight: assert property (@(posedge i_core_clk)
      s_go_in(OP_SHIFT_ALL, 1'b0) |=>
         bank_r[7] == $past(bank_r[6]) && bank_r[0] == $past(i_word_in))
      else $error("eight-stage shift wrong");
   chk_first_four: assert property (@(posedge i_core_clk)
      s_go(OP_SHIFT_FIRST4) |=> bank_r[3] == $past(bank_r[2]) && bank_r[4] == $past(bank_r[4]))
      else $error("first four shift wrong");
   chk_upper_four: assert property (@(posedge i_core_clk)
      s_go_in(OP_SHIFT_UPPER, 1'b0) |=>
         bank_r[4] == $past(i_word_in) && bank_r[7] == $past(bank_r[6]) && bank_r[0] == $past(bank_r[0]))
      else $error("upper four shift wrong");
   chk_pair_shift: assert property (@(posedge i_core_clk)
      s_go(OP_PAIR_THREE) |=> bank_r[5] == $past(bank_r[4]) && bank_r[6] == $past(bank_r[6]))
      else $error("pair shift wrong");
   chk_pair_four: assert property (@(posedge i_core_clk)
      s_go_in(OP_PAIR_FOUR, 1'b0) |=> bank_r[7] == $past(bank_r[6]) && bank_r[6] == $past(i_word_in))
      else $error("last pair shift wrong");
   chk_pair_two: assert property (@(posedge i_core_clk)
      s_go(OP_PAIR_TWO) |=>
         bank_r[2] == $past(i_word_in) && bank_r[3] === $past(bank_r[2]) && bank_r[1] === $past(bank_r[1]))
      else $error("second pair shift wrong");
   chk_hold_code: assert property (@(posedge i_core_clk)
      i_op_code == OP_HOLD || (ctl_r.seven_mode && i_op_code == OP_LOAD_LAST) |=> bank_r === $past(bank_r))
      else $error("hold code changed the bank");
   chk_seven_load: assert property (@(posedge i_core_clk)
      s_go_in(OP_PAIR_FOUR, 1'b1) |=> bank_r[6] == $past(i_word_in) && bank_r[7] === $past(bank_r[7]))
      else $error("seven-register load of the seventh wrong");
   chk_seven_shift: assert property (@(posedge i_core_clk)
      s_go_in(OP_SHIFT_ALL, 1'b1) |=>
         bank_r[6] == $past(bank_r[5]) && bank_r[7] === $past(bank_r[7]))
      else $error("seven-stage shift wrong");
   chk_seven_upper: assert property (@(posedge i_core_clk)
      s_go_in(OP_SHIFT_UPPER, 1'b1) |=>
         bank_r[4] == $past(i_word_in) && bank_r[6] === $past(bank_r[5]) && bank_r[7] === $past(bank_r[7]))
      else $error("seven-register upper shift wrong");
   chk_out_mux: assert property (@(posedge i_core_clk)
      o_word_out === ((ctl_r.seven_mode && i_output_pick == 3'h7) ? i_word_in : bank_r[i_output_pick]))
      else $error("output mux wrong");
   chk_out_enable: assert property (@(posedge i_core_clk)
      o_word_out_oe == !i_output_enable_n)
      else $error("output enable wrong");
endmodule : mlpr_top
`default_nettype wire

// [pkg/mlpr_pkg.sv]
`default_nettype none
package mlpr_pkg;
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned NUM_REGS   = 8;
   localparam int unsigned SPILL_DEPTH = 32;
   localparam int unsigned LEVEL_W    = 6;

   typedef logic [WORD_W-1:0]             mlpr_word_t;
   typedef logic [NUM_REGS-1:0][WORD_W-1:0] mlpr_bank_t;

   // operation codes
   localparam logic [3:0] OP_SHIFT_ALL   = 4'h8;
   localparam logic [3:0] OP_SHIFT_FIRST4 = 4'h9;
   localparam logic [3:0] OP_SHIFT_UPPER = 4'ha;
   localparam logic [3:0] OP_PAIR_ONE    = 4'hb;
   localparam logic [3:0] OP_PAIR_TWO    = 4'hc;
   localparam logic [3:0] OP_PAIR_THREE  = 4'hd;
   localparam logic [3:0] OP_PAIR_FOUR   = 4'he;
   localparam logic [3:0] OP_HOLD        = 4'hf;
   localparam logic [3:0] OP_LOAD_LAST   = 4'h7;

   // register port map
   localparam logic [3:0] ADDR_CTRL      = 4'h0;
   localparam logic [3:0] ADDR_STATUS    = 4'h4;
   localparam logic [3:0] ADDR_PEEK_SEL  = 4'h8;
   localparam logic [3:0] ADDR_PEEK_DATA = 4'hc;
   localparam int unsigned CTRL_SEVEN_BIT = 0;
   localparam int unsigned CTRL_SPILL_BIT = 1;
   localparam int unsigned STAT_STALL_BIT = 8;
   localparam int unsigned STAT_OP_LSB    = 12;
   localparam logic        RST_SEVEN      = 1'b0;
   localparam logic        RST_SPILL      = 1'b0;

   typedef struct packed {
      logic        seven_mode;
      logic        spill_en;
      logic [2:0]  peek_sel;
      logic [3:0]  last_op;
      logic [31:0] rd_data;
   } mlpr_ctl_s;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } mlpr_bus_s;
endpackage : mlpr_pkg
`default_nettype wire
